// *** asc_pkg.sv ***
// Purpose: constants and carrier types for the async static memory host controller
// Assumes: 25 MHz REF_CLK, 40 ns period
// Notes:   times kept in ns as printed, cycle counts derived from them
package asc_pkg;
  localparam int CLK_NS        = 40;
  localparam int ADDR_W        = 19;  // 512K words
  localparam int DATA_W        = 16;
  localparam int BYTE_W        = 8;
  // fast grade timing in ns (slow grade figures below)
  localparam int READ_CYCLE_TIME_NS      = 45;
  localparam int ADDR_ACCESS_TIME_NS     = 45;
  localparam int OUTEN_ACCESS_TIME_NS    = 22;
  localparam int SELECT_ACCESS_TIME_NS   = 45;
  localparam int BYTESEL_ACCESS_TIME_NS  = 45;
  localparam int WRITE_CYCLE_TIME_NS     = 45;
  localparam int WRITE_PULSE_WIDTH_NS    = 35;
  localparam int SELECT_TO_WRITE_END_NS  = 35;
  localparam int BYTESEL_TO_WRITE_END_NS = 35;
  localparam int SLOW_ACCESS_NS          = 55;
  localparam int SLOW_OUTEN_NS           = 25;
  localparam int SLOW_WRITE_END_NS       = 40;
  localparam int SLOW_CYCLE_NS           = 55;
  // ceil(ns / period), at least one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int MAX_OF_READ_NS =
    (SLOW_ACCESS_NS > SLOW_OUTEN_NS) ? SLOW_ACCESS_NS : SLOW_OUTEN_NS;
  localparam int READ_WAIT_CYC  = ns_to_cyc(MAX_OF_READ_NS);
  localparam int WRITE_PULSE_CYC = ns_to_cyc(SLOW_WRITE_END_NS);
  localparam int CYCLE_CYC      = ns_to_cyc(SLOW_CYCLE_NS);
  localparam int CNT_W          = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
  localparam logic [1:0] LANES_NONE = 2'h3;  // active-low lane selects, both off

  typedef enum logic [2:0] {
    ASC_IDLE  = 3'b000,
    ASC_RSET  = 3'b001,
    ASC_RWAIT = 3'b010,
    ASC_WSET  = 3'b011,
    ASC_WPULS = 3'b100,
    ASC_WEND  = 3'b101
  } asc_state_t;

  // user request
  typedef struct packed {
    logic              write;
    logic [1:0]        lane_n;   // bit1 upper, bit0 lower, active low
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asc_req_t;

  // memory pins driven by the host
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              chip_select_low_n;
    logic              chip_select_high;
    logic              write_n;
    logic              outen_n;
    logic              upper_byte_sel_n;
    logic              lower_byte_sel_n;
    logic [DATA_W-1:0] dq_out;
    logic [DATA_W-1:0] dq_oe;
  } asc_pins_t;

  typedef struct packed {
    asc_state_t        st;
    logic [CNT_W-1:0]  cnt;
    asc_pins_t         pins;
    logic              ready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        lane_n;
  } asc_st_t;
endpackage

// *** asc_host.sv ***
// Purpose: synchronous host that runs read and write cycles on an async 512Kx16 memory
// Assumes: REF_CLK 25 MHz, NRST synchronous active low, DQ_IN synchronous to REF_CLK
// Notes:   one request at a time; timing uses the slower grade so both grades work
module asc_host
  import asc_pkg::*;
#(
  parameter int READ_WAIT  = READ_WAIT_CYC,
  parameter int WRITE_WAIT = WRITE_PULSE_CYC
) (
  input  wire logic                    REF_CLK,
  input  wire logic                    NRST,
  input  wire logic                    REQ_VALID,
  input  wire asc_pkg::asc_req_t       REQ,
  output logic                         REQ_READY,
  output logic                         RD_VALID,
  output logic [asc_pkg::DATA_W-1:0]   RD_DATA,
  output asc_pkg::asc_pins_t           MEM,
  input  wire logic [asc_pkg::DATA_W-1:0] DQ_IN
);
  import asc_pkg::*;

  // refuse waits too short for the memory or too long for the counter
  if (READ_WAIT < READ_WAIT_CYC || WRITE_WAIT < WRITE_PULSE_CYC ||
      READ_WAIT >= (1 << CNT_W) || WRITE_WAIT >= (1 << CNT_W)) begin : g_bad
    $error("asc_host: wait parameters out of range");
  end

  localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(READ_WAIT);
  localparam logic [CNT_W-1:0] WR_CNT = CNT_W'(WRITE_WAIT);

  // idle pin state: deselected, strobe and output enable high, bus released
  function automatic asc_pins_t idle_pins(input logic [ADDR_W-1:0] a);
    asc_pins_t p;
    p                   = '0;
    p.addr              = a;
    p.chip_select_low_n = 1'b1;
    p.chip_select_high  = 1'b0;
    p.write_n           = 1'b1;
    p.outen_n           = 1'b1;
    p.upper_byte_sel_n  = 1'b1;
    p.lower_byte_sel_n  = 1'b1;
    return p;
  endfunction

  // per-bit output enable for the lanes picked by active-low selects
  function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] ln);
    return {{BYTE_W{~ln[1]}}, {BYTE_W{~ln[0]}}};
  endfunction

  asc_st_t s_q;
  asc_st_t s_d;

  // next-state logic for the whole access sequencer
  always_comb begin
    s_d        = s_q;
    s_d.rvalid = 1'b0;
    case (s_q.st)
      ASC_IDLE: begin
        s_d.ready = 1'b1;
        if (REQ_VALID && s_q.ready && REQ.lane_n != LANES_NONE) begin
          s_d.ready     = 1'b0;
          s_d.lane_n    = REQ.lane_n;
          s_d.pins      = idle_pins(REQ.addr);  // address settles first
          s_d.pins.dq_out = REQ.wdata;
          s_d.st        = REQ.write ? ASC_WSET : ASC_RSET;
        end
      end
      ASC_RSET: begin
        // select, lanes and output enable together, strobe kept high
        s_d.pins.chip_select_low_n = 1'b0;
        s_d.pins.chip_select_high  = 1'b1;
        s_d.pins.outen_n           = 1'b0;
        s_d.pins.upper_byte_sel_n  = s_q.lane_n[1];
        s_d.pins.lower_byte_sel_n  = s_q.lane_n[0];
        s_d.pins.write_n           = 1'b1;
        s_d.cnt                    = RD_CNT;   // worst access time rounded up
        s_d.st                     = ASC_RWAIT;
      end
      ASC_RWAIT: begin
        s_d.cnt = s_q.cnt - CNT_ONE;
        if (s_q.cnt == CNT_ONE) begin
          s_d.rdata  = DQ_IN & lane_mask(s_q.lane_n);  // sample only live lanes
          s_d.rvalid = 1'b1;
          s_d.pins   = idle_pins(s_q.pins.addr);       // deselect, strobe high
          s_d.st     = ASC_IDLE;
        end
      end
      ASC_WSET: begin
        // all write terms go active on the same edge, output enable stays high
        s_d.pins.chip_select_low_n = 1'b0;
        s_d.pins.chip_select_high  = 1'b1;
        s_d.pins.write_n           = 1'b0;
        s_d.pins.upper_byte_sel_n  = s_q.lane_n[1];   // unselected lane untouched
        s_d.pins.lower_byte_sel_n  = s_q.lane_n[0];
        s_d.pins.dq_oe             = lane_mask(s_q.lane_n);
        s_d.cnt                    = WR_CNT;  // pulse and select overlap
        s_d.st                     = ASC_WPULS;
      end
      ASC_WPULS: begin
        s_d.cnt = s_q.cnt - CNT_ONE;
        if (s_q.cnt == CNT_ONE) begin
          // strobe, selects and lanes all drop together so any edge ends it
          s_d.pins       = idle_pins(s_q.pins.addr);
          s_d.pins.dq_out = s_q.pins.dq_out;
          s_d.pins.dq_oe  = s_q.pins.dq_oe;    // data held past write end
          s_d.st         = ASC_WEND;
        end
      end
      ASC_WEND: begin
        s_d.pins.dq_oe = '0;                   // release bus one cycle after end
        s_d.st         = ASC_IDLE;
      end
      default: begin
        s_d.st   = ASC_IDLE;
        s_d.pins = idle_pins(s_q.pins.addr);
      end
    endcase
  end

  // state register
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      s_q      <= '0;
      s_q.st   <= ASC_IDLE;
      s_q.pins <= idle_pins('0);
      s_q.lane_n <= LANES_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  assign REQ_READY = s_q.ready;
  assign RD_VALID  = s_q.rvalid;
  assign RD_DATA   = s_q.rdata;
  assign MEM       = s_q.pins;

  // read side: strobe high, a lane picked, host off the bus, quiet when deselected
  chk_read_no_strobe: assert property (@(posedge REF_CLK) disable iff (!NRST)
    !MEM.outen_n |-> MEM.write_n) else $error("strobe low in read");
  chk_read_lanes: assert property (@(posedge REF_CLK) disable iff (!NRST)
    !MEM.outen_n |-> !(MEM.upper_byte_sel_n && MEM.lower_byte_sel_n))
    else $error("read with no lane selected");
  chk_bus_no_fight: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (MEM.dq_oe != '0) |-> MEM.outen_n) else $error("bus driven in read");
  chk_idle_quiet: assert property (@(posedge REF_CLK) disable iff (!NRST)
    MEM.chip_select_low_n |-> MEM.write_n && MEM.outen_n && !MEM.chip_select_high)
    else $error("control active while deselected");

  // write side: all terms start together, overlap the minimum, end together
  chk_write_all_on: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $fell(MEM.write_n) |-> !MEM.chip_select_low_n && MEM.chip_select_high &&
    !(MEM.upper_byte_sel_n && MEM.lower_byte_sel_n)) else $error("bad write start");
  chk_write_setup: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $fell(MEM.write_n) |-> $stable(MEM.dq_out)) else $error("data moved at write start");
  // counted back from the end: the overlap of strobe, selects and lanes meets the minimum
  chk_write_width: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $rose(MEM.write_n) |-> $past(!MEM.write_n && !MEM.chip_select_low_n &&
    MEM.chip_select_high && !(MEM.upper_byte_sel_n && MEM.lower_byte_sel_n),
    WRITE_PULSE_CYC)) else $error("write pulse short");
  chk_write_end_all: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $rose(MEM.write_n) |-> MEM.chip_select_low_n && MEM.upper_byte_sel_n &&
    MEM.lower_byte_sel_n) else $error("write end not together");
  chk_data_hold: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $rose(MEM.write_n) |-> $stable(MEM.dq_out) && (MEM.dq_oe != '0))
    else $error("data dropped at write end");
  chk_lane_drive: assert property (@(posedge REF_CLK) disable iff (!NRST)
    !MEM.write_n |-> MEM.dq_oe == lane_mask({MEM.upper_byte_sel_n, MEM.lower_byte_sel_n}))
    else $error("driving unselected lane");

  // timing: wait cycles before the sample, address settled before select
  chk_read_wait: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $fell(MEM.outen_n) |-> !RD_VALID[*2] ##1 RD_VALID) else $error("read wait wrong");
  chk_read_cycle: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $rose(MEM.outen_n) |-> $past(!MEM.outen_n && !MEM.chip_select_low_n, READ_WAIT_CYC))
    else $error("read access short");
  chk_addr_setup: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $rose(MEM.chip_select_high) |-> $stable(MEM.addr))
    else $error("address late at select");
  chk_addr_stable: assert property (@(posedge REF_CLK) disable iff (!NRST)
    !MEM.chip_select_low_n && !$rose(MEM.chip_select_high) |-> $stable(MEM.addr))
    else $error("address moved while selected");

  // request side: a request with no lane is dropped, cycles keep their minimum length
  chk_req_refused: assert property (@(posedge REF_CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && (REQ.lane_n == LANES_NONE) |=> REQ_READY)
    else $error("laneless request taken");
  chk_cycle_gap: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $fell(REQ_READY) |-> !REQ_READY[*4]) else $error("cycle too short");

  cov_read:    cover property (@(posedge REF_CLK) disable iff (!NRST) RD_VALID);
  cov_write:   cover property (@(posedge REF_CLK) disable iff (!NRST) $rose(MEM.write_n));
  cov_upper:   cover property (@(posedge REF_CLK) disable iff (!NRST)
    !MEM.write_n && MEM.lower_byte_sel_n);
  cov_lower:   cover property (@(posedge REF_CLK) disable iff (!NRST)
    !MEM.outen_n && MEM.upper_byte_sel_n);
  cov_refused: cover property (@(posedge REF_CLK) disable iff (!NRST)
    REQ_VALID && REQ_READY && (REQ.lane_n == LANES_NONE));
endmodule

// *** asc_mem_model.sv ***
// Purpose: behavioural async 512Kx16 memory facing the host controller
// Assumes: host pins as declared in asc_pkg, no clock on the memory side
// Notes:   released data lines show a toggling pattern, never the last value
module asc_mem_model
  import asc_pkg::*;
(
  input  wire asc_pkg::asc_pins_t              MEM,
  output logic [asc_pkg::DATA_W-1:0]           DQ
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem_q [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] float_q = 16'hA5A5;
  logic [DATA_W-1:0] lane_en;
  logic [DATA_W-1:0] word;
  logic              sel;
  logic              rd;
  // access times of the slower grade: a host timed for them suits both grades
  localparam int ACC_NS  = SLOW_ACCESS_NS;
  localparam int OE_NS   = SLOW_OUTEN_NS;
  localparam int HOLD_NS = 10;  // old word kept after an address change
  realtime                t_acc    = 0.0;
  realtime                t_oe     = 0.0;
  realtime                t_hold   = 0.0;
  int                     seq      = 0;
  int                     wake_q   = 0;
  logic [DATA_W-1:0]      hold_q   = 16'h0000;
  logic [ADDR_W+DATA_W:0] acc_seen = '0;
  logic                   oe_seen  = 1'b1;
  // floating bus pattern, off the clock grid
  always #13 float_q = ~float_q;
  // selection and lane decode
  assign sel = !MEM.chip_select_low_n && MEM.chip_select_high
               && !(MEM.upper_byte_sel_n && MEM.lower_byte_sel_n);
  assign lane_en = {{8{!MEM.upper_byte_sel_n}}, {8{!MEM.lower_byte_sel_n}}};
  assign rd = sel && MEM.write_n && !MEM.outen_n;
  // store selected lanes while the write overlap lasts
  always @(MEM) begin
    if (sel && !MEM.write_n) begin
      word = mem_q.exists(MEM.addr) ? mem_q[MEM.addr] : 16'h0000;
      mem_q[MEM.addr] = (word & ~lane_en) | (MEM.dq_out & lane_en);
    end
  end
  // restart the access clocks on each address, select, lane or output enable change
  always @(MEM.addr or sel or lane_en or MEM.outen_n) begin
    if (MEM.addr !== acc_seen[ADDR_W+DATA_W:DATA_W+1]) begin
      hold_q = DQ;
      t_hold = $realtime;
      seq    = seq + 1;
      wake_q <= #(HOLD_NS) seq;
    end
    if ({MEM.addr, sel, lane_en} !== acc_seen) begin  // no power-up delay
      t_acc  = $realtime;
      seq    = seq + 1;
      wake_q <= #(ACC_NS) seq;
    end
    if (MEM.outen_n !== oe_seen) begin
      t_oe   = $realtime;
      seq    = seq + 1;
      wake_q <= #(OE_NS) seq;
    end
    acc_seen = {MEM.addr, sel, lane_en};
    oe_seen  = MEM.outen_n;
  end
  // bus level: contention gives unknown, released lanes float, data unknown until access
  always @(MEM or rd or lane_en or wake_q or float_q or hold_q or t_acc or t_oe or t_hold) begin
    for (int i = 0; i < DATA_W; i++) begin
      if (rd && lane_en[i]) begin
        if (MEM.dq_oe[i]) begin
          DQ[i] = 1'bx;
        end else if (($realtime - t_hold) < HOLD_NS) begin
          DQ[i] = hold_q[i];
        end else if (($realtime - t_acc) < ACC_NS || ($realtime - t_oe) < OE_NS) begin
          DQ[i] = 1'bx;
        end else begin
          DQ[i] = mem_q.exists(MEM.addr) ? mem_q[MEM.addr][i] : 1'bx;
        end
      end else begin
        DQ[i] = MEM.dq_oe[i] ? MEM.dq_out[i] : float_q[i];
      end
    end
  end
endmodule

// *** tb.sv ***
// Purpose: self-checking bench for the async memory host controller
// Assumes: default wait parameters, behavioural memory on the far side
// Notes:   each scenario is its own task and judges its own results
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import asc_pkg::*;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic              req_valid = 1'b0;
  asc_req_t          req = '0;
  logic              req_ready;
  logic              rd_valid;
  logic [DATA_W-1:0] rd_data;
  asc_pins_t         mem;
  logic [DATA_W-1:0] dq;
  int                n_fail = 0;
  int                n_checks = 0;
  int                cyc = 0;
  asc_host i_asc_host (.REF_CLK(clk), .NRST(nrst), .REQ_VALID(req_valid), .REQ(req),
    .REQ_READY(req_ready), .RD_VALID(rd_valid), .RD_DATA(rd_data), .MEM(mem), .DQ_IN(dq));
  asc_mem_model i_asc_mem_model (.MEM(mem), .DQ(dq));
  // 25 MHz clock
  initial forever #20 clk = ~clk;
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      final_report();
    end
  end
  // present one request at the edge where ready is high
  task automatic issue(input logic wr, input logic [1:0] ln, input logic [18:0] a,
                       input logic [15:0] d);
    while (req_ready !== 1'b1) @(posedge clk) #1;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{write: wr, lane_n: ln, addr: a, wdata: d};
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
  endtask
  task automatic do_read(input logic [1:0] ln, input logic [18:0] a, input logic [15:0] exp);
    int n;
    issue(1'b0, ln, a, 16'h0000);
    for (n = 0; n < 10 && rd_valid !== 1'b1; n++) begin
      check("strobe in read", mem.write_n, 1'b1);
      @(posedge clk) #1;
    end
    check("read done", rd_valid, 1'b1);
    check("read data", rd_data, exp);
  endtask
  task automatic s_reset();
    check("select low idle", mem.chip_select_low_n, 1'b1);
    check("strobe idle", mem.write_n, 1'b1);
    check("drive idle", mem.dq_oe, 16'h0000);
    check("ready after reset", req_ready, 1'b1);
  endtask
  task automatic s_words();
    issue(1'b1, 2'h0, 19'h00000, 16'h1234);
    issue(1'b1, 2'h0, 19'h7FFFF, 16'hBEEF);
    do_read(2'h0, 19'h00000, 16'h1234);
    do_read(2'h0, 19'h7FFFF, 16'hBEEF);
  endtask
  task automatic s_lanes();
    issue(1'b1, 2'h0, 19'h00005, 16'hABCD);
    issue(1'b1, 2'h2, 19'h00005, 16'h0077);
    do_read(2'h0, 19'h00005, 16'hAB77);
    issue(1'b1, 2'h1, 19'h00005, 16'h5500);
    do_read(2'h0, 19'h00005, 16'h5577);
    do_read(2'h2, 19'h00005, 16'h0077);
    do_read(2'h1, 19'h00005, 16'h5500);
  endtask
  task automatic s_refuse();
    issue(1'b1, 2'h3, 19'h00005, 16'hFFFF);
    check("ready kept", req_ready, 1'b1);
    check("no select", mem.chip_select_high, 1'b0);
    do_read(2'h0, 19'h00005, 16'h5577);
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk) #1;
    s_reset();
    s_words();
    s_lanes();
    s_refuse();
    final_report();
  end
endmodule
